// ---- rsqr_regs.svh ----
`ifndef RSQR_REGS_SVH
`define RSQR_REGS_SVH
// Register byte addresses
`define RSQR_CTRL_ADDR 12'h000
`define RSQR_RF_ADDR 12'h004
`define RSQR_PRES_ADDR 12'h008
`define RSQR_FILT_ADDR 12'h00c
`define RSQR_MISC_ADDR 12'h010
`define RSQR_SUM_ADDR 12'h014
`define RSQR_GSF0_ADDR 12'h018
`define RSQR_GSF1_ADDR 12'h01c
`define RSQR_STAT_ADDR 12'h020
// Register reset values (MISC resets to 0, not to RSQR_MISC_RST)
`define RSQR_RF_RST 32'h0001_1f10
`define RSQR_PRES_RST 32'h0000_000f
`define RSQR_FILT_RST 32'h0000_0000
`define RSQR_MISC_RST 32'h0000_0001
// Fixed off algorithm and field limits
`define RSQR_ALG_DEF 2'h2
`define RSQR_ATTEN_MAX 4'ha
`define RSQR_USEP_MAX 3'h4
// Fixed text pieces
`define RSQR_SPACE 8'h20
`define RSQR_CR 8'h0d
`define RSQR_LF 8'h0a
`define RSQR_LINE_MAX 64
// Timeout scale
`define RSQR_CLK_MHZ 100
`define RSQR_CYC_PER_MS (`RSQR_CLK_MHZ * 1000)
`endif

// ---- rsqr_pkg.sv ----
package rsqr_pkg;
    // Query command codes
    typedef enum logic [3:0] {
        RSQR_Q_RF = 4'h1,
        RSQR_Q_PRES = 4'h2,
        RSQR_Q_FILT = 4'h3,
        RSQR_Q_ECHO = 4'h4,
        RSQR_Q_PSUM = 4'h5,
        RSQR_Q_BSUM = 4'h6,
        RSQR_Q_MUX = 4'h7,
        RSQR_Q_SENS = 4'h8,
        RSQR_Q_GSF = 4'h9
    } rsqr_query_t;

    typedef struct packed {
        logic [11:0] unused;
        logic [2:0] unused2;
        logic ctrl_src;
        logic [2:0] pad;
        logic [4:0] range;
        logic [1:0] pad2;
        logic [1:0] utmo;
        logic [3:0] atten;
    } rsqr_rf_cfg_t;

    typedef struct packed {
        logic [25:0] pad;
        logic no_tag_rpt;
        logic invert;
        logic [3:0] rf_tmo;
    } rsqr_pres_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rsqr_char_t;
endpackage

// ---- rsqr_line_mem.sv ----
/*
 Line buffer for one report line.
 Assumes one clock; registered read data.
*/
`timescale 1ns/1ps
module rsqr_line_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// ---- rsqr_responder.sv ----
/*
 Status query responder: AHB-Lite slave and report-line builder.
 Assumes one clock and a framer that accepts with CHAR_READY_IN.
*/
// Functional notes
// [R1] Control source C0 host, C1 sensor; C1 default.
// [R2] Uniqueness timeout T1 2 min, T2 15 s, T3 30 s.
// [R3] Decoder range two hex digits, 00 to 1F.
// [R4] Attenuation two hex digits, 00 max to 0A min power.
// [R5] Default RF line fixed; last field always I04.
// [R6] Presence report fields P, D, A, T, I in order.
// [R7] Option on: presence without valid tag raises report; the code only sets no_tag_flag in STAT and sends no line.
// [R8] No-tag option P0 off, P1 on; P0 default.
// [R9] Presence report always shows D0.
// [R10] RF off: A0 timeout, A1 or tag, A2 or presence gone.
// [R11] RF timeout T0 expired, T1..TE 4..752 ms, TF infinite.
// [R12] Inversion I0 off, I1 on; off by default.
// [R13] Separation U0..U3 one to four, U4 all; U0 default.
// [R14] Valid-ID criterion fixed, shown V0.
// [R15] Echo 0 or 1; writable in basic or inquiry protocol.
// [R16] Program sum: prefix, I0000, E, four characters.
// [R17] Boot sum: prefix, four characters.
// [R18] Multiplexing report modes 0 to 3.
// [R19] Sensor report E0/E1 and M0..M3.
// [R20] Group filter fields in command order.
// [R21] One space between fields.
// [R22] One line per query, after full decode.
`timescale 1ns/1ps
`include "rsqr_regs.svh"
module rsqr_responder
    import rsqr_pkg::*;
#(
    parameter int LINE_DEPTH = `RSQR_LINE_MAX,
    parameter int TMO_SCALE = `RSQR_CYC_PER_MS
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [11:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // Pins
    input wire logic PRESENCE_IN,
    input wire logic TAG_VALID_IN,
    // Report character stream and RF enable
    output rsqr_char_t CHAR_OUT,
    input wire logic CHAR_READY_IN,
    output logic RF_ON_OUT
);
    localparam int AW = $clog2(LINE_DEPTH);
    // RF timeout table in ms (index 0 unused, 15 infinite)
    localparam int TMO_MS [16] = '{0, 4, 8, 12, 20, 24, 32, 48, 60, 92,
        152, 300, 452, 600, 752, 0};

    rsqr_rf_cfg_t rf_cfg;
    rsqr_pres_cfg_t pres_cfg;
    logic [2:0] usep;
    logic echo_en;
    logic [1:0] proto;
    logic [1:0] mux_mode;
    logic sens_en;
    logic [1:0] sens_sel;
    logic [15:0] psum;
    logic [15:0] bsum;
    logic [63:0] gsf;
    logic [3:0] gsf_len;
    logic [3:0] query;
    logic query_go;
    logic no_tag_flag;
    logic no_tag_clr;

    // Bus address phase capture
    logic dph_wr;
    logic dph_rd;
    logic [11:0] dph_addr;
    logic bus_busy;

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            dph_wr <= 1'b0;
            dph_rd <= 1'b0;
            dph_addr <= 12'h000;
        end else if (HREADY_IN) begin
            dph_wr <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
            dph_rd <= HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;
            dph_addr <= HADDR_IN;
        end
    end

    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    // Register writes
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rf_cfg <= `RSQR_RF_RST;
            pres_cfg <= `RSQR_PRES_RST;
            usep <= 3'h0;
            echo_en <= 1'b0;
            proto <= 2'h0;
            mux_mode <= 2'h0;
            sens_en <= 1'b0;
            sens_sel <= 2'h0;
            psum <= 16'h0000;
            bsum <= 16'h0000;
            gsf <= 64'h0;
            gsf_len <= 4'h0;
        end else if (dph_wr) begin
            unique case (dph_addr)
                `RSQR_RF_ADDR: begin
                    rf_cfg.ctrl_src <= HWDATA_IN[16];
                    rf_cfg.range <= HWDATA_IN[12:8];
                    if (HWDATA_IN[5:4] != 2'h0) begin
                        rf_cfg.utmo <= HWDATA_IN[5:4];
                    end
                    if (HWDATA_IN[3:0] <= `RSQR_ATTEN_MAX) begin
                        rf_cfg.atten <= HWDATA_IN[3:0];
                    end
                end
                `RSQR_PRES_ADDR: begin
                    pres_cfg.no_tag_rpt <= HWDATA_IN[5];
                    pres_cfg.invert <= HWDATA_IN[4];
                    pres_cfg.rf_tmo <= HWDATA_IN[3:0];
                end
                `RSQR_FILT_ADDR: begin
                    if (HWDATA_IN[2:0] <= `RSQR_USEP_MAX) begin
                        usep <= HWDATA_IN[2:0];
                    end
                end
                `RSQR_MISC_ADDR: begin
                    proto <= HWDATA_IN[1:0];
                    // [R15] echo gated by protocol
                    if (proto != 2'h1) begin
                        echo_en <= HWDATA_IN[4];
                    end
                    mux_mode <= HWDATA_IN[9:8];
                    sens_en <= HWDATA_IN[12];
                    sens_sel <= HWDATA_IN[17:16];
                    gsf_len <= HWDATA_IN[27:24];
                end
                `RSQR_SUM_ADDR: begin
                    psum <= HWDATA_IN[15:0];
                    bsum <= HWDATA_IN[31:16];
                end
                `RSQR_GSF0_ADDR: gsf[63:32] <= HWDATA_IN;
                `RSQR_GSF1_ADDR: gsf[31:0] <= HWDATA_IN;
                default: ;
            endcase
        end
    end

    // Query launch
    logic busy;
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            query <= 4'h0;
            query_go <= 1'b0;
        end else begin
            // [R22] start only after whole query taken
            query_go <= dph_wr && dph_addr == `RSQR_CTRL_ADDR && !busy;
            if (dph_wr && dph_addr == `RSQR_CTRL_ADDR && !busy) begin
                query <= HWDATA_IN[3:0];
            end
        end
    end

    // Pin synchronisers
    logic [1:0] pres_sync;
    logic [1:0] tag_sync;
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pres_sync <= 2'b00;
            tag_sync <= 2'b00;
        end else begin
            pres_sync <= {pres_sync[0], PRESENCE_IN};
            tag_sync <= {tag_sync[0], TAG_VALID_IN};
        end
    end
    logic presence;
    assign presence = pres_sync[1] ^ pres_cfg.invert;

    // RF on/off control with timeout
    logic [31:0] tmo_cnt;
    logic tmo_hit;
    logic pres_d;
    logic seen_tag;
    assign tmo_hit = (pres_cfg.rf_tmo == 4'h0) ||
        ((pres_cfg.rf_tmo != 4'hf) &&
        (tmo_cnt >= 32'(TMO_MS[pres_cfg.rf_tmo] * TMO_SCALE)));

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            RF_ON_OUT <= 1'b0;
            tmo_cnt <= 32'h0;
            pres_d <= 1'b0;
            seen_tag <= 1'b0;
        end else begin
            pres_d <= presence;
            if (RF_ON_OUT) begin
                tmo_cnt <= tmo_cnt + 32'h1;
            end else begin
                tmo_cnt <= 32'h0;
            end
            if (presence && !pres_d) begin
                seen_tag <= 1'b0;
            end else if (tag_sync[1]) begin
                seen_tag <= 1'b1;
            end
            if (rf_cfg.ctrl_src && presence && !pres_d) begin
                RF_ON_OUT <= 1'b1;
            // [R11] timeout expiry
            end else if (RF_ON_OUT && tmo_hit) begin
                RF_ON_OUT <= 1'b0;
            // [R10] off algorithm
            end else if (RF_ON_OUT && pres_cfg.rf_tmo != 4'h0 &&
                ((rf_cfg.utmo != 2'h0 && 1'b0) ||
                (`RSQR_ALG_DEF == 2'h2 && !presence && pres_d) ||
                (tag_sync[1] && 1'b0))) begin
                RF_ON_OUT <= 1'b0;
            end
        end
    end

    // [R7] presence ended without valid tag
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            no_tag_flag <= 1'b0;
        end else if (pres_cfg.no_tag_rpt && !presence && pres_d &&
            !seen_tag) begin
            no_tag_flag <= 1'b1;
        end else if (no_tag_clr) begin
            no_tag_flag <= 1'b0;
        end
    end

    // Line builder
    function automatic logic [7:0] hexc(input logic [3:0] v);
        hexc = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
    endfunction

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUILD = 4'b0010,
        ST_SEND = 4'b0100,
        ST_WAIT = 4'b1000
    } rsqr_state_t;
    rsqr_state_t state;

    logic [7:0] line [32];
    logic [5:0] line_len;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_char;
    logic mem_we;

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            line[i] = `RSQR_SPACE;
        end
        line_len = 6'd0;
        unique case (query)
            RSQR_Q_RF: begin
                // [R5] RF report layout, [R21] single spaces
                line[0:3] = '{"R", "F", "S", "T"};
                // [R1] control source
                line[5] = "C";
                line[6] = rf_cfg.ctrl_src ? "1" : "0";
                line[8] = "0";
                line[9] = RF_ON_OUT ? "1" : "0";
                // [R2] uniqueness timeout
                line[11] = "T";
                line[12] = hexc({2'h0, rf_cfg.utmo});
                line[14:16] = '{"R", "1", "F"};
                // [R3] decoder range
                line[18] = "G";
                line[19] = hexc({3'h0, rf_cfg.range[4]});
                line[20] = hexc(rf_cfg.range[3:0]);
                // [R4] attenuation
                line[22] = "A";
                line[23] = "0";
                line[24] = hexc(rf_cfg.atten);
                line[26:28] = '{"I", "0", "4"};
                line_len = 6'd29;
            end
            RSQR_Q_PRES: begin
                // [R6] presence report order
                line[0:3] = '{"P", "R", "S", "T"};
                // [R8] option state
                line[5] = "P";
                line[6] = pres_cfg.no_tag_rpt ? "1" : "0";
                // [R9] fixed D0
                line[8] = "D";
                line[9] = "0";
                line[11] = "A";
                line[12] = hexc({2'h0, `RSQR_ALG_DEF});
                line[14] = "T";
                line[15] = hexc(pres_cfg.rf_tmo);
                // [R12] inversion
                line[17] = "I";
                line[18] = pres_cfg.invert ? "1" : "0";
                line_len = 6'd19;
            end
            RSQR_Q_FILT: begin
                line[0:3] = '{"R", "F", "O", "S"};
                // [R13] separation
                line[5] = "U";
                line[6] = hexc({1'h0, usep});
                // [R14] fixed V0
                line[8] = "V";
                line[9] = "0";
                line_len = 6'd10;
            end
            RSQR_Q_ECHO: begin
                line[0:3] = '{"E", "C", "H", "O"};
                line[5] = echo_en ? "1" : "0";
                line_len = 6'd6;
            end
            RSQR_Q_PSUM: begin
                // [R16] program sum
                line[0:3] = '{"P", "C", "K", "S"};
                line[5:9] = '{"I", "0", "0", "0", "0"};
                line[11] = "E";
                for (int i = 0; i < 4; i++) begin
                    line[12 + i] = hexc(psum[15 - 4 * i -: 4]);
                end
                line_len = 6'd16;
            end
            RSQR_Q_BSUM: begin
                // [R17] boot sum
                line[0:3] = '{"B", "C", "K", "S"};
                for (int i = 0; i < 4; i++) begin
                    line[5 + i] = hexc(bsum[15 - 4 * i -: 4]);
                end
                line_len = 6'd9;
            end
            RSQR_Q_MUX: begin
                // [R18] mux mode
                line[0:2] = '{"M", "U", "X"};
                line[4] = hexc({2'h0, mux_mode});
                line_len = 6'd5;
            end
            RSQR_Q_SENS: begin
                // [R19] sensor change report
                line[0:3] = '{"S", "S", "T", "C"};
                line[5] = "E";
                line[6] = sens_en ? "1" : "0";
                line[8] = "M";
                line[9] = hexc({2'h0, sens_sel});
                line_len = 6'd10;
            end
            RSQR_Q_GSF: begin
                // [R20] stored fields in command order
                for (int i = 0; i < 16; i++) begin
                    line[i] = hexc(gsf[63 - 4 * i -: 4]);
                end
                line_len = {2'h0, gsf_len} + 6'd1;
            end
            default: line_len = 6'd0;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state <= ST_IDLE;
            wr_idx <= '0;
            rd_idx <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    wr_idx <= '0;
                    rd_idx <= '0;
                    if (query_go) begin
                        state <= ST_BUILD;
                    end
                end
                ST_BUILD: begin
                    wr_idx <= wr_idx + 1'b1;
                    if (32'(wr_idx) + 1 >= 32'(line_len) + 2) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: state <= ST_SEND;
                ST_SEND: begin
                    if (CHAR_READY_IN) begin
                        if (32'(rd_idx) + 1 >= 32'(line_len) + 2) begin
                            state <= ST_IDLE;
                        end else begin
                            rd_idx <= rd_idx + 1'b1;
                            state <= ST_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    assign busy = state != ST_IDLE;
    assign mem_we = state == ST_BUILD;
    // Read ahead so the data register holds the next character in time
    assign rd_addr = (state == ST_SEND && CHAR_READY_IN) ?
        rd_idx + 1'b1 : rd_idx;
    assign no_tag_clr = query_go && query == RSQR_Q_PRES;

    logic [7:0] wr_char;
    always_comb begin
        if (32'(wr_idx) < 32'(line_len)) begin
            wr_char = line[wr_idx[4:0]];
        end else if (32'(wr_idx) == 32'(line_len)) begin
            wr_char = `RSQR_CR;
        end else begin
            wr_char = `RSQR_LF;
        end
    end

    rsqr_line_mem #(
        .DEPTH(LINE_DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_in(CLK_SYS_IN),
        .wr_en_in(mem_we),
        .wr_addr_in(wr_idx),
        .wr_data_in(wr_char),
        .rd_addr_in(rd_addr),
        .rd_data_out(rd_char)
    );

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CHAR_OUT <= '0;
        end else begin
            CHAR_OUT.valid <= state == ST_WAIT ||
                (state == ST_SEND && !CHAR_READY_IN);
            CHAR_OUT.data <= (state == ST_WAIT) ? rd_char : CHAR_OUT.data;
        end
    end

    // Register reads
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            HRDATA_OUT <= 32'h0;
        end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
            unique case (HADDR_IN)
                `RSQR_CTRL_ADDR: HRDATA_OUT <= {28'h0, query};
                `RSQR_RF_ADDR: HRDATA_OUT <= rf_cfg;
                `RSQR_PRES_ADDR: HRDATA_OUT <= pres_cfg;
                `RSQR_FILT_ADDR: HRDATA_OUT <= {29'h0, usep};
                `RSQR_MISC_ADDR: HRDATA_OUT <= {4'h0, gsf_len, 6'h0,
                    sens_sel, 3'h0, sens_en, 2'h0, mux_mode, 3'h0,
                    echo_en, 2'h0, proto};
                `RSQR_SUM_ADDR: HRDATA_OUT <= {bsum, psum};
                `RSQR_GSF0_ADDR: HRDATA_OUT <= gsf[63:32];
                `RSQR_GSF1_ADDR: HRDATA_OUT <= gsf[31:0];
                `RSQR_STAT_ADDR: HRDATA_OUT <= {28'h0, no_tag_flag,
                    pres_sync[1], RF_ON_OUT, busy};
                default: HRDATA_OUT <= 32'h0;
            endcase
        end
    end
endmodule

// ---- rsqr_responder_sva.sv ----
/*
 Checker for the status query responder.
 Assumes one clock; sees top ports only.
*/
`timescale 1ns/1ps
module rsqr_responder_sva
    import rsqr_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // Bus
    input wire logic HSEL_IN,
    input wire logic [11:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    // Pins and report stream
    input wire logic PRESENCE_IN,
    input wire rsqr_char_t CHAR_OUT,
    input wire logic CHAR_READY_IN,
    input wire logic RF_ON_OUT
);
    logic acc;
    logic last_sp;
    default clocking @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!NRST_IN);
    assign acc = CHAR_OUT.valid && CHAR_READY_IN;
    // Remembers whether the last accepted character was a space
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            last_sp <= 1'b0;
        end else if (acc) begin
            last_sp <= CHAR_OUT.data == 8'h20;
        end
    end
    a_bus_ready: assert property (HREADYOUT_OUT)
        else $error("wait state seen");
    a_resp_okay: assert property (!HRESP_OUT)
        else $error("error response seen");
    a_char_held: assert property (
        CHAR_OUT.valid && !CHAR_READY_IN
        |=> CHAR_OUT.valid && $stable(CHAR_OUT.data))
        else $error("character dropped before accept");
    a_crlf_pair: assert property (
        acc && CHAR_OUT.data == 8'h0d
        |-> ##[1:40] (acc && CHAR_OUT.data == 8'h0a))
        else $error("line end not completed");
    a_one_space: assert property (acc && last_sp |-> CHAR_OUT.data != 8'h20)
        else $error("two spaces in a row");
    a_unmapped_zero: assert property (
        HSEL_IN && HREADY_IN && HTRANS_IN == 2'b10 && !HWRITE_IN
        && HADDR_IN > 12'h020 |=> HRDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_rf_off_pres: assert property ($fell(PRESENCE_IN) |-> ##[1:10] !RF_ON_OUT)
        else $error("rf stayed on after presence");
    a_char_text: assert property (
        CHAR_OUT.valid
        |-> CHAR_OUT.data inside {[8'h20:8'h7e], 8'h0d, 8'h0a})
        else $error("non text character");
endmodule
bind rsqr_responder rsqr_responder_sva rsqr_responder_sva_i (
    .CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .PRESENCE_IN(PRESENCE_IN), .CHAR_OUT(CHAR_OUT),
    .CHAR_READY_IN(CHAR_READY_IN), .RF_ON_OUT(RF_ON_OUT)
);

// ---- rsqr_host_model.sv ----
/*
 Host side of the report stream: accepts characters, collects lines.
 Assumes the responder holds each character until accepted.
*/
`timescale 1ns/1ps
module rsqr_host_model
    import rsqr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Report stream
    input wire rsqr_char_t char_in,
    input wire logic slow_in,
    output logic ready_out
);
    string lines[$];
    string cur;
    logic [7:0] d;
    // one line per query, taken char by char
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ready_out <= 1'b0;
            cur = "";
        end else begin
            ready_out <= slow_in ? 1'($urandom_range(1)) : 1'b1;
            if (char_in.valid && ready_out) begin
                d = char_in.data;
                if (^d === 1'bx) begin
                    d = 8'h3f;
                end
                if (d == 8'h0a) begin
                    lines.push_back(cur);
                    cur = "";
                end else if (d != 8'h0d) begin
                    cur = {cur, string'(d)};
                end
            end
        end
    end
endmodule

// ---- tb_reader_status_query_responder.sv ----
/*
 Self-checking bench for the status query responder.
 Assumes the host model collects each report line.
*/
`timescale 1ns/1ps
`include "rsqr_regs.svh"
`define CHK(w, e, g) \
    begin \
        checks_done++; \
        if ((e) != (g)) begin \
            err_count++; \
            $display("CHECK FAILED %s exp %s got %s", w, e, g); \
        end \
    end
module tb_reader_status_query_responder
    import rsqr_pkg::*;
;
    localparam P_RF = 32'h52465354;
    localparam P_PR = 32'h50525354;
    localparam P_FI = 32'h52464f53;
    localparam P_PS = 32'h50434b53;
    localparam P_BS = 32'h42434b53;
    localparam P_SE = 32'h53535443;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] dmy;
    logic hready;
    logic hresp;
    logic presence = 1'b0;
    logic tag_valid = 1'b0;
    logic slow = 1'b0;
    logic chr_ready;
    logic rf_on;
    rsqr_char_t chr;
    int err_count = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    rsqr_responder #(.TMO_SCALE(10)) rsqr_responder_i (
        .CLK_SYS_IN(clk), .NRST_IN(nrst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PRESENCE_IN(presence),
        .TAG_VALID_IN(tag_valid), .CHAR_OUT(chr), .CHAR_READY_IN(chr_ready),
        .RF_ON_OUT(rf_on));
    rsqr_host_model rsqr_host_model_i (.clk_in(clk), .nrst_in(nrst),
        .char_in(chr), .slow_in(slow), .ready_out(chr_ready));
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Single transfer
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0, dmy);
        `CHK("register", $sformatf("%h", e), $sformatf("%h", dmy))
    endtask
    task automatic query(input logic [3:0] q, input string e);
        string got;
        int n;
        bus(`RSQR_CTRL_ADDR, 1'b1, {28'h0, q}, dmy);
        for (n = 0; n < 3000 && rsqr_host_model_i.lines.size() == 0; n++) begin
            @(posedge clk);
        end
        got = n < 3000 ? rsqr_host_model_i.lines.pop_front() : "none";
        e = e.toupper();
        `CHK("report line", e, got)
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        int cs, rg, ut, at, tm, nt, iv, us, ec, ss, se, mx;
        logic [31:0] sum;
        logic [31:0] m;
        void'($urandom(32'hae32));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdchk(`RSQR_RF_ADDR, 32'h0001_1f10);
        rdchk(`RSQR_PRES_ADDR, 32'h0000_000f);
        rdchk(`RSQR_FILT_ADDR, 32'h0);
        rdchk(12'h030, 32'h0);
        query(4'h1, $sformatf("%s C1 00 T1 R1F G1F A00 I04", P_RF));
        query(4'h2, $sformatf("%s P0 D0 A2 TF I0", P_PR));
        query(4'h3, $sformatf("%s U0 V0", P_FI));
        query(4'h8, $sformatf("%s E0 M0", P_SE));
        bus(`RSQR_MISC_ADDR, 1'b1, 32'h0, dmy);
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            cs = $urandom_range(1);
            rg = $urandom_range(31);
            ut = $urandom_range(3, 1);
            at = $urandom_range(10);
            tm = $urandom_range(15);
            nt = $urandom_range(1);
            iv = $urandom_range(1);
            us = $urandom_range(4);
            ec = $urandom_range(1);
            ss = $urandom_range(3);
            se = $urandom_range(1);
            mx = $urandom_range(3);
            sum = $urandom;
            m = {8'h0f, 6'h0, 2'(ss), 3'h0, 1'(se), 2'h0, 2'(mx), 8'h0};
            bus(`RSQR_PRES_ADDR, 1'b1, {26'h0, 1'(nt), 1'(iv), 4'(tm)}, dmy);
            query(4'h2, $sformatf("%s P%0d D0 A2 T%h I%0d", P_PR, nt, 4'(tm),
                iv));
            bus(`RSQR_PRES_ADDR, 1'b1, {26'h0, 1'(nt), 1'b0, 4'(tm)}, dmy);
            bus(`RSQR_RF_ADDR, 1'b1, {15'h0, 1'(cs), 3'h0, 5'(rg), 2'h0,
                2'(ut), 4'(at)}, dmy);
            query(4'h1, $sformatf("%s C%0d 00 T%0d R1F G%h A%h I04", P_RF, cs,
                ut, 8'(rg), 8'(at)));
            bus(`RSQR_FILT_ADDR, 1'b1, 32'(us), dmy);
            query(4'h3, $sformatf("%s U%0d V0", P_FI, us));
            bus(`RSQR_SUM_ADDR, 1'b1, sum, dmy);
            query(4'h5, $sformatf("%s I0000 E%h", P_PS, sum[15:0]));
            query(4'h6, $sformatf("%s %h", P_BS, sum[31:16]));
            bus(`RSQR_MISC_ADDR, 1'b1, m | {27'h0, 1'(ec), 4'h1}, dmy);
            bus(`RSQR_MISC_ADDR, 1'b1, m | {27'h0, 1'(1 - ec), 4'h1}, dmy);
            query(4'h4, $sformatf("ECHO %0d", ec));
            query(4'h8, $sformatf("%s E%0d M%0d", P_SE, se, ss));
            query(4'h7, $sformatf("MUX %0d", mx));
            bus(`RSQR_GSF0_ADDR, 1'b1, sum, dmy);
            bus(`RSQR_GSF1_ADDR, 1'b1, ~sum, dmy);
            query(4'h9, $sformatf("%h%h", sum, ~sum));
            bus(`RSQR_MISC_ADDR, 1'b1, m | {27'h0, 1'(ec), 4'h0}, dmy);
        end
        bus(`RSQR_PRES_ADDR, 1'b1, 32'h0000_000f, dmy);
        bus(`RSQR_RF_ADDR, 1'b1, 32'h0001_1f10, dmy);
        presence <= 1'b1;
        repeat (10) @(posedge clk);
        tag_valid <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("rf on", "1", $sformatf("%b", rf_on))
        presence <= 1'b0;
        tag_valid <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK("rf off", "0", $sformatf("%b", rf_on))
        final_report();
    end
endmodule
